// *** design/bwau_pkg.sv ***
// shared constants and types of the byte and word arithmetic unit
package bwau_pkg;
   localparam int BYTE_W = 8;
   localparam int WORD_W = 16;
   localparam int FLAG_W = 4;
   localparam int DIV_STEPS = 8;
   // flag positions inside the condition flags register
   localparam int FLG_N = 3;
   localparam int FLG_Z = 2;
   localparam int FLG_V = 1;
   localparam int FLG_C = 0;
   localparam logic [3:0] FLAGS_RST = 4'h0;
   localparam logic [7:0] BCD_ADJ_LO = 8'h06;
   localparam logic [7:0] BCD_ADJ_HI = 8'h60;
   localparam logic [3:0] BCD_NIB_MAX = 4'h9;
   localparam logic [7:0] BCD_BYTE_MAX = 8'h99;
   localparam logic [15:0] STEP_ONE = 16'h0001;
   localparam logic [15:0] STEP_TWO = 16'h0002;

   typedef enum logic [4:0] {
      BWAU_ADD_B, BWAU_SUB_B, BWAU_ADD_B_LIT,
      BWAU_ADD_W, BWAU_SUB_W,
      BWAU_ADDC_B, BWAU_SUBC_B,
      BWAU_INC_B, BWAU_STEPDN_B,
      BWAU_ADDS_1, BWAU_ADDS_2, BWAU_WSUB_1, BWAU_WSUB_2,
      BWAU_BCD_SUM, BWAU_BCD_DIFF,
      BWAU_MUL, BWAU_DIV,
      BWAU_COMPARE_B, BWAU_COMPARE_W,
      BWAU_COMPL_B
   } bwau_op_t;
endpackage

// *** design/bwau_divider.sv ***
// restoring 16 by 8 unsigned divider, one quotient bit per cycle
`timescale 1ns/10ps
module bwau_divider (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // request
   input  wire logic        start,
   input  wire logic [15:0] dividend,
   input  wire logic [7:0]  divisor,
   // answer
   output logic             done,
   output logic [7:0]       quotient,
   output logic [7:0]       remainder,
   output logic             div_zero
);
   logic [8:0]  rem;
   logic [7:0]  quo;
   logic [7:0]  dvs;
   logic [3:0]  cnt;
   logic        busy;
   logic [8:0]  trial;
   logic [9:0]  diff;

   assign trial = {rem[7:0], quo[7]};
   assign diff  = {1'b0, trial} - {2'b00, dvs};

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rem <= 9'h000;
         quo <= 8'h00;
         dvs <= 8'h00;
         cnt <= 4'h0;
         busy <= 1'b0;
         done <= 1'b0;
         div_zero <= 1'b0;
         quotient <= 8'h00;
         remainder <= 8'h00;
      end else begin
         done <= 1'b0;
         if (start && !busy) begin
            // high byte is the partial remainder, low byte shifts in
            rem <= {1'b0, dividend[15:8]};
            quo <= dividend[7:0];
            dvs <= divisor;
            cnt <= 4'(bwau_pkg::DIV_STEPS);
            busy <= 1'b1;
         end else if (busy) begin
            if ({rem[8], trial} >= {2'b00, dvs}) begin
               rem <= diff[8:0];
               quo <= {quo[6:0], 1'b1};
            end else begin
               rem <= {rem[7:0], quo[7]};
               quo <= {quo[6:0], 1'b0};
            end
            cnt <= cnt - 4'h1;
            if (cnt == 4'h1) begin
               busy <= 1'b0;
               done <= 1'b1;
               div_zero <= (dvs == 8'h00);
               if ({rem[8], trial} >= {2'b00, dvs}) begin
                  quotient <= {quo[6:0], 1'b1};
                  remainder <= diff[7:0];
               end else begin
                  quotient <= {quo[6:0], 1'b0};
                  remainder <= trial[7:0];
               end
            end
         end
      end
   end
endmodule

// *** design/bwau_core.sv ***
// byte and word integer arithmetic datapath with condition flags
`timescale 1ns/10ps
module bwau_core (
   // clock and reset
   input  wire logic              ref_clk,
   input  wire logic              rst,
   // request from the decoder
   input  wire logic              op_valid,
   input  wire bwau_pkg::bwau_op_t op_code,
   input  wire logic              use_literal,
   input  wire logic [15:0]       dest_value,
   input  wire logic [15:0]       source_register,
   input  wire logic [7:0]        literal_operand,
   // answer to the register file
   output logic                   busy,
   output logic                   result_valid,
   output logic                   result_write,
   output logic                   result_is_word,
   output logic [15:0]            result_value,
   output logic                   op_illegal,
   output logic [3:0]             condition_flags_register
);
   logic [15:0] div_dividend;
   logic [7:0]  div_divisor;
   logic        div_start;
   logic        div_done;
   logic [7:0]  div_quo;
   logic [7:0]  div_rem;
   logic        div_zero;
   logic        div_wait;

   logic [7:0]  rd_b;
   logic [7:0]  src_b;
   logic [8:0]  sum9;
   logic [16:0] sum17;
   logic [7:0]  bcd_corr;
   logic        bcd_carry;
   logic [15:0] next_value;
   logic [3:0]  next_flags;
   logic        next_write;
   logic        next_word;
   logic        next_illegal;
   logic        cin;

   bwau_divider u_div (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .start     (div_start),
      .dividend  (div_dividend),
      .divisor   (div_divisor),
      .done      (div_done),
      .quotient  (div_quo),
      .remainder (div_rem),
      .div_zero  (div_zero)
   );

   assign rd_b = dest_value[7:0];
   assign src_b = use_literal ? literal_operand : source_register[7:0];
   assign cin  = condition_flags_register[bwau_pkg::FLG_C];
   assign div_start = op_valid && !div_wait
                      && op_code == bwau_pkg::BWAU_DIV;
   assign div_dividend = dest_value;
   assign div_divisor  = source_register[7:0];

   // one combinational result and flag set per opcode
   always_comb begin
      next_value = dest_value;
      next_flags = condition_flags_register;
      next_write = 1'b0;
      next_word = 1'b0;
      next_illegal = 1'b0;
      sum9 = 9'h000;
      sum17 = 17'h00000;
      bcd_corr = 8'h00;
      bcd_carry = 1'b0;
      case (op_code)
         bwau_pkg::BWAU_ADD_B, bwau_pkg::BWAU_ADD_B_LIT,
         bwau_pkg::BWAU_ADDC_B, bwau_pkg::BWAU_INC_B: begin
            if (op_code == bwau_pkg::BWAU_INC_B)
               sum9 = {1'b0, rd_b} + 9'h001;
            else if (op_code == bwau_pkg::BWAU_ADDC_B)
               sum9 = {1'b0, rd_b} + {1'b0, src_b} + {8'h00, cin};
            else
               sum9 = {1'b0, rd_b} + {1'b0, src_b};
            next_illegal = use_literal
                           && op_code == bwau_pkg::BWAU_ADD_B;
            next_value = {dest_value[15:8], sum9[7:0]};
            next_write = !next_illegal;
            next_flags[bwau_pkg::FLG_V] = (rd_b[7] == src_b[7] ||
               op_code == bwau_pkg::BWAU_INC_B) &&
               (sum9[7] != rd_b[7]) &&
               !(op_code == bwau_pkg::BWAU_INC_B && rd_b != 8'h7f);
            if (op_code != bwau_pkg::BWAU_INC_B)
               next_flags[bwau_pkg::FLG_C] = sum9[8];
            next_flags[bwau_pkg::FLG_N] = sum9[7];
            next_flags[bwau_pkg::FLG_Z] = (sum9[7:0] == 8'h00);
         end
         bwau_pkg::BWAU_SUB_B, bwau_pkg::BWAU_SUBC_B,
         bwau_pkg::BWAU_STEPDN_B, bwau_pkg::BWAU_COMPARE_B,
         bwau_pkg::BWAU_COMPL_B: begin
            if (op_code == bwau_pkg::BWAU_STEPDN_B)
               sum9 = {1'b0, rd_b} - 9'h001;
            else if (op_code == bwau_pkg::BWAU_SUBC_B)
               sum9 = {1'b0, rd_b} - {1'b0, src_b} - {8'h00, cin};
            else if (op_code == bwau_pkg::BWAU_COMPL_B)
               sum9 = 9'h000 - {1'b0, rd_b};
            else
               sum9 = {1'b0, rd_b} - {1'b0, src_b};
            next_illegal = use_literal
                           && op_code == bwau_pkg::BWAU_SUB_B;
            next_value = {dest_value[15:8], sum9[7:0]};
            next_write = !next_illegal
                         && op_code != bwau_pkg::BWAU_COMPARE_B;
            if (op_code == bwau_pkg::BWAU_STEPDN_B)
               next_flags[bwau_pkg::FLG_V] = (rd_b == 8'h80);
            else if (op_code == bwau_pkg::BWAU_COMPL_B)
               next_flags[bwau_pkg::FLG_V] = (rd_b == 8'h80);
            else
               next_flags[bwau_pkg::FLG_V] = (rd_b[7] != src_b[7]) &&
                                             (sum9[7] != rd_b[7]);
            if (op_code != bwau_pkg::BWAU_STEPDN_B)
               next_flags[bwau_pkg::FLG_C] = sum9[8];
            next_flags[bwau_pkg::FLG_N] = sum9[7];
            next_flags[bwau_pkg::FLG_Z] = (sum9[7:0] == 8'h00);
         end
         bwau_pkg::BWAU_ADD_W, bwau_pkg::BWAU_SUB_W,
         bwau_pkg::BWAU_COMPARE_W: begin
            if (op_code == bwau_pkg::BWAU_ADD_W)
               sum17 = {1'b0, dest_value} + {1'b0, source_register};
            else
               sum17 = {1'b0, dest_value} - {1'b0, source_register};
            next_illegal = use_literal;
            next_value = sum17[15:0];
            next_word = 1'b1;
            next_write = !use_literal && op_code != bwau_pkg::BWAU_COMPARE_W;
            next_flags[bwau_pkg::FLG_V] =
               (op_code == bwau_pkg::BWAU_ADD_W) ?
               (dest_value[15] == source_register[15] &&
                sum17[15] != dest_value[15]) :
               (dest_value[15] != source_register[15] &&
                sum17[15] != dest_value[15]);
            next_flags[bwau_pkg::FLG_C] = sum17[16];
            next_flags[bwau_pkg::FLG_N] = sum17[15];
            next_flags[bwau_pkg::FLG_Z] = (sum17[15:0] == 16'h0000);
         end
         bwau_pkg::BWAU_ADDS_1, bwau_pkg::BWAU_ADDS_2,
         bwau_pkg::BWAU_WSUB_1, bwau_pkg::BWAU_WSUB_2: begin
            // flags untouched, word_minus_small and its add partner
            case (op_code)
               bwau_pkg::BWAU_ADDS_1:
                  next_value = dest_value + bwau_pkg::STEP_ONE;
               bwau_pkg::BWAU_ADDS_2:
                  next_value = dest_value + bwau_pkg::STEP_TWO;
               bwau_pkg::BWAU_WSUB_1:
                  next_value = dest_value - bwau_pkg::STEP_ONE;
               default:
                  next_value = dest_value - bwau_pkg::STEP_TWO;
            endcase
            next_word = 1'b1;
            next_write = 1'b1;
         end
         bwau_pkg::BWAU_BCD_SUM: begin
            // correction from prior carry plus nibble range
            if (cin || rd_b > bwau_pkg::BCD_BYTE_MAX) begin
               bcd_corr = bwau_pkg::BCD_ADJ_HI;
               bcd_carry = 1'b1;
            end
            if (rd_b[3:0] > bwau_pkg::BCD_NIB_MAX)
               bcd_corr = bcd_corr | bwau_pkg::BCD_ADJ_LO;
            next_value = {dest_value[15:8], rd_b + bcd_corr};
            next_write = 1'b1;
            next_flags[bwau_pkg::FLG_C] = bcd_carry;
            next_flags[bwau_pkg::FLG_N] = next_value[7];
            next_flags[bwau_pkg::FLG_Z] = (next_value[7:0] == 8'h00);
         end
         bwau_pkg::BWAU_BCD_DIFF: begin
            if (cin)
               bcd_corr = bwau_pkg::BCD_ADJ_HI;
            if (rd_b[3:0] > bwau_pkg::BCD_NIB_MAX)
               bcd_corr = bcd_corr | bwau_pkg::BCD_ADJ_LO;
            next_value = {dest_value[15:8], rd_b - bcd_corr};
            next_write = 1'b1;
            next_flags[bwau_pkg::FLG_N] = next_value[7];
            next_flags[bwau_pkg::FLG_Z] = (next_value[7:0] == 8'h00);
         end
         bwau_pkg::BWAU_MUL: begin
            next_value = rd_b * source_register[7:0];
            next_word = 1'b1;
            next_write = !use_literal;
            next_illegal = use_literal;
         end
         default: begin
            next_illegal = 1'b1;
         end
      endcase
   end

   // divider wait tracking
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst)
         div_wait <= 1'b0;
      else if (div_start)
         div_wait <= 1'b1;
      else if (div_done)
         div_wait <= 1'b0;
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst)
         busy <= 1'b0;
      else
         busy <= div_start || (div_wait && !div_done);
   end

   // result and flag registers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         result_valid <= 1'b0;
         result_write <= 1'b0;
         result_is_word <= 1'b0;
         result_value <= 16'h0000;
         op_illegal <= 1'b0;
         condition_flags_register <= bwau_pkg::FLAGS_RST;
      end else begin
         result_valid <= 1'b0;
         result_write <= 1'b0;
         op_illegal <= 1'b0;
         if (div_done) begin
            result_valid <= 1'b1;
            result_write <= !div_zero;
            result_is_word <= 1'b1;
            result_value <= {div_rem, div_quo};
            condition_flags_register[bwau_pkg::FLG_Z] <= div_zero;
            condition_flags_register[bwau_pkg::FLG_N] <= div_quo[7];
         end else if (op_valid && !div_wait &&
                      op_code != bwau_pkg::BWAU_DIV) begin
            result_valid <= 1'b1;
            result_write <= next_write;
            result_is_word <= next_word;
            result_value <= next_value;
            op_illegal <= next_illegal;
            if (!next_illegal)
               condition_flags_register <= next_flags;
         end
      end
   end

   a_cmp_no_write: assert property (@(posedge ref_clk)
      disable iff (rst) op_valid && !div_wait &&
      op_code == bwau_pkg::BWAU_COMPARE_B
      |=> result_valid && !result_write)
      else $error("compare wrote the destination");
   a_sub_imm_refused: assert property (@(posedge ref_clk)
      disable iff (rst) op_valid && !div_wait && use_literal &&
      op_code == bwau_pkg::BWAU_SUB_B |=> op_illegal && !result_write)
      else $error("immediate subtract was accepted");
   a_word_imm_refused: assert property (@(posedge ref_clk)
      disable iff (rst) op_valid && !div_wait && use_literal &&
      (op_code == bwau_pkg::BWAU_ADD_W ||
       op_code == bwau_pkg::BWAU_COMPARE_W) |=> op_illegal)
      else $error("word op with immediate accepted");
   a_mul_product: assert property (@(posedge ref_clk)
      disable iff (rst) op_valid && !div_wait && !use_literal &&
      op_code == bwau_pkg::BWAU_MUL |=> result_value ==
      $past(dest_value[7:0]) * $past(source_register[7:0]))
      else $error("wrong product");
   a_div_latency: assert property (@(posedge ref_clk)
      disable iff (rst) div_start
      |-> ##[9:10] result_valid && result_is_word)
      else $error("divide answer late");
   a_div_zero_kept: assert property (@(posedge ref_clk)
      disable iff (rst) div_done && div_zero
      |=> result_valid && !result_write)
      else $error("divide by zero wrote a result");
   a_neg_value: assert property (@(posedge ref_clk)
      disable iff (rst) op_valid && !div_wait &&
      op_code == bwau_pkg::BWAU_COMPL_B
      |=> result_value[7:0] == 8'h00 - $past(dest_value[7:0]))
      else $error("wrong negate");
   a_inc_value: assert property (@(posedge ref_clk)
      disable iff (rst) op_valid && !div_wait &&
      op_code == bwau_pkg::BWAU_INC_B
      |=> result_value[7:0] == $past(dest_value[7:0]) + 8'h01)
      else $error("wrong increment");
   a_word_step_two: assert property (@(posedge ref_clk)
      disable iff (rst) op_valid && !div_wait &&
      op_code == bwau_pkg::BWAU_WSUB_2
      |=> result_value == $past(dest_value) - 16'h0002)
      else $error("wrong word step");
   a_illegal_flags: assert property (@(posedge ref_clk)
      disable iff (rst) op_valid && !div_wait && next_illegal &&
      op_code != bwau_pkg::BWAU_DIV |=> $stable(condition_flags_register))
      else $error("refused op changed the flags");
   a_zero_flag: assert property (@(posedge ref_clk)
      disable iff (rst) result_valid && !op_illegal && !result_is_word &&
      result_value[7:0] == 8'h00
      |-> condition_flags_register[bwau_pkg::FLG_Z])
      else $error("zero flag not set");
endmodule

// *** tb/bwau_regfile_model.sv ***
// register file stand-in that feeds the destination word and takes results
`timescale 1ns/10ps
module bwau_regfile_model (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // preload from the bench
   input  wire logic        load,
   input  wire logic [15:0] load_value,
   // write-back from the core
   input  wire logic        result_write,
   input  wire logic        result_is_word,
   input  wire logic [15:0] result_value,
   // destination operand
   output logic [15:0]      dest_value
);
   logic [15:0] held_word;

   // a word written at this edge is already seen by a request taken at it
   assign dest_value = !result_write ? held_word :
                       result_is_word ? result_value :
                       {held_word[15:8], result_value[7:0]};

   // a byte write leaves the upper byte of the register alone
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         held_word <= 16'h0000;
      end else if (load) begin
         held_word <= load_value;
      end else if (result_write && result_is_word) begin
         held_word <= result_value;
      end else if (result_write) begin
         held_word[7:0] <= result_value[7:0];
      end
   end
endmodule

// *** tb/testbench.sv ***
// self-checking bench of the arithmetic core beside a register file model
`timescale 1ns/10ps
module testbench;
   typedef struct {
      bwau_pkg::bwau_op_t op;
      logic               li;
      logic [15:0]        d;
      logic [15:0]        s;
      logic [1:0]         k;
      logic [15:0]        v;
      logic [3:0]         f;
      logic [3:0]         m;
   } bwau_row_t;

   logic               ref_clk = 1'b0, rst = 1'b1, op_valid = 1'b0;
   logic               use_literal = 1'b0, load = 1'b0;
   bwau_pkg::bwau_op_t op_code = bwau_pkg::BWAU_ADD_B;
   logic [15:0]        source_register = 16'h0000, load_value = 16'h0000;
   logic [7:0]         literal_operand = 8'h00;
   logic [15:0]        dest_value, result_value;
   logic               busy, result_valid, result_write, result_is_word;
   logic               op_illegal;
   logic [3:0]         condition_flags_register;
   int                 fails = 0, n_checks = 0;

   always #5 ref_clk = ~ref_clk;

   bwau_core bwau_core_inst (
      .ref_clk                  (ref_clk),
      .rst                      (rst),
      .op_valid                 (op_valid),
      .op_code                  (op_code),
      .use_literal              (use_literal),
      .dest_value               (dest_value),
      .source_register          (source_register),
      .literal_operand          (literal_operand),
      .busy                     (busy),
      .result_valid             (result_valid),
      .result_write             (result_write),
      .result_is_word           (result_is_word),
      .result_value             (result_value),
      .op_illegal               (op_illegal),
      .condition_flags_register (condition_flags_register)
   );

   bwau_regfile_model bwau_regfile_model_inst (
      .ref_clk        (ref_clk),
      .rst            (rst),
      .load           (load),
      .load_value     (load_value),
      .result_write   (result_write),
      .result_is_word (result_is_word),
      .result_value   (result_value),
      .dest_value     (dest_value)
   );

   // k: 0 byte write, 1 word write, 2 flags only, 3 refused
   bwau_row_t rows [31] = '{
      '{bwau_pkg::BWAU_ADD_B,0,16'h1234,16'h00cc,0,16'h1200,4'h5,4'hf},
      '{bwau_pkg::BWAU_ADDC_B,0,16'h1210,16'h0005,0,16'h1216,4'h0,4'hf},
      '{bwau_pkg::BWAU_SUBC_B,1,16'h0010,16'h0020,0,16'h00f0,4'h9,4'hf},
      '{bwau_pkg::BWAU_SUB_B,0,16'h0080,16'h0001,0,16'h007f,4'h2,4'hf},
      '{bwau_pkg::BWAU_ADD_W,0,16'h8000,16'h8000,1,16'h0000,4'h7,4'hf},
      '{bwau_pkg::BWAU_INC_B,0,16'h00ff,16'h0000,0,16'h0000,4'h5,4'hf},
      '{bwau_pkg::BWAU_STEPDN_B,0,16'h0080,16'h0000,0,16'h007f,4'h3,4'hf},
      '{bwau_pkg::BWAU_SUB_W,0,16'h1000,16'h0001,1,16'h0fff,4'h0,4'hf},
      '{bwau_pkg::BWAU_ADD_B_LIT,1,16'hab7f,16'h0001,0,16'hab80,4'ha,4'hf},
      '{bwau_pkg::BWAU_ADDS_1,0,16'h00ff,16'h0000,1,16'h0100,4'ha,4'hf},
      '{bwau_pkg::BWAU_ADDS_2,0,16'hffff,16'h0000,1,16'h0001,4'ha,4'hf},
      '{bwau_pkg::BWAU_WSUB_1,0,16'h0000,16'h0000,1,16'hffff,4'ha,4'hf},
      '{bwau_pkg::BWAU_WSUB_2,0,16'h0001,16'h0000,1,16'hffff,4'ha,4'hf},
      '{bwau_pkg::BWAU_ADD_B,0,16'h0015,16'h0027,0,16'h003c,4'h0,4'hf},
      '{bwau_pkg::BWAU_BCD_SUM,0,16'h003c,16'h0000,0,16'h0042,4'h0,4'h1},
      '{bwau_pkg::BWAU_ADD_B,0,16'h0090,16'h0090,0,16'h0020,4'h3,4'hf},
      '{bwau_pkg::BWAU_BCD_SUM,0,16'h0020,16'h0000,0,16'h0080,4'h1,4'h1},
      '{bwau_pkg::BWAU_SUB_B,0,16'h0042,16'h0015,0,16'h002d,4'h0,4'hf},
      '{bwau_pkg::BWAU_BCD_DIFF,0,16'h002d,16'h0000,0,16'h0027,4'h0,4'h1},
      '{bwau_pkg::BWAU_MUL,0,16'h00ff,16'h00ff,1,16'hfe01,4'h0,4'h0},
      '{bwau_pkg::BWAU_COMPARE_B,0,16'h0005,16'h0005,2,16'h0000,4'h4,4'hf},
      '{bwau_pkg::BWAU_COMPARE_B,1,16'h0003,16'h0005,2,16'h0000,4'h9,4'hf},
      '{bwau_pkg::BWAU_COMPARE_W,0,16'h0100,16'h0200,2,16'h0000,4'h9,4'hf},
      '{bwau_pkg::BWAU_COMPL_B,0,16'h3401,16'h0000,0,16'h34ff,4'h9,4'hf},
      '{bwau_pkg::BWAU_ADD_W,1,16'h0001,16'h0001,3,16'h0000,4'h9,4'hf},
      '{bwau_pkg::BWAU_SUB_W,1,16'h0001,16'h0001,3,16'h0000,4'h9,4'hf},
      '{bwau_pkg::BWAU_COMPARE_W,1,16'h0001,16'h0001,3,16'h0000,4'h9,4'hf},
      '{bwau_pkg::BWAU_MUL,1,16'h0001,16'h0001,3,16'h0000,4'h9,4'hf},
      '{bwau_pkg::BWAU_SUB_B,1,16'h0001,16'h0001,3,16'h0000,4'h9,4'hf},
      '{bwau_pkg::BWAU_ADD_B,1,16'h0001,16'h0001,3,16'h0000,4'h9,4'hf},
      '{bwau_pkg::BWAU_DIV,0,16'h0107,16'h0010,1,16'h0710,4'h0,4'h0}
   };

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic report_and_stop();
      if (fails == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // n counts falling edges waited after op_valid has been dropped
   task automatic wait_answer(output int n);
      n = 0;
      while (result_valid !== 1'b1 && op_illegal !== 1'b1 && n < 15) begin
         @(negedge ref_clk);
         n++;
      end
      if (n == 15) begin
         fails++;
         report_and_stop();
      end
   endtask

   task automatic run(input bwau_row_t r);
      int n;
      @(negedge ref_clk);
      load = 1'b1;
      load_value = r.d;
      @(negedge ref_clk);
      load = 1'b0;
      op_valid = 1'b1;
      op_code = r.op;
      use_literal = r.li;
      source_register = r.s;
      literal_operand = r.s[7:0];
      @(negedge ref_clk);
      op_valid = 1'b0;
      wait_answer(n);
      chk(16'(op_illegal), 16'(r.k == 2'd3));
      chk(16'(result_write), 16'(r.k < 2'd2));
      if (r.k < 2'd2) begin
         chk(result_value, r.v);
         chk(16'(result_is_word), 16'(r.k));
      end
      chk(16'(condition_flags_register & r.m), 16'(r.f & r.m));
   endtask

   initial begin
      int        n;
      bwau_row_t zero_div;
      zero_div = '{bwau_pkg::BWAU_DIV, 0, 16'h1234, 16'h0000, 2,
                   16'h0000, 4'h4, 4'h4};
      repeat (4) @(posedge ref_clk);
      @(negedge ref_clk);
      rst = 1'b0;
      foreach (rows[i]) begin
         run(rows[i]);
      end
      run(zero_div);
      // divide while a second request is held up during it
      @(negedge ref_clk);
      load = 1'b1;
      load_value = 16'h00ff;
      @(negedge ref_clk);
      load = 1'b0;
      op_valid = 1'b1;
      op_code = bwau_pkg::BWAU_DIV;
      use_literal = 1'b0;
      source_register = 16'h0010;
      @(negedge ref_clk);
      op_code = bwau_pkg::BWAU_ADD_B;
      chk(16'(busy), 16'h0001);
      repeat (3) @(negedge ref_clk);
      op_valid = 1'b0;
      wait_answer(n);
      chk(16'(n), 16'h0006);
      chk(result_value, 16'h0f0f);
      @(negedge ref_clk);
      chk(dest_value, 16'h0f0f);
      chk(16'(result_valid), 16'h0000);
      // back-to-back byte add then subtract on the same register
      load = 1'b1;
      load_value = 16'h0010;
      @(negedge ref_clk);
      load = 1'b0;
      op_valid = 1'b1;
      source_register = 16'h0001;
      @(negedge ref_clk);
      op_code = bwau_pkg::BWAU_SUB_B;
      source_register = 16'h0003;
      chk(result_value, 16'h0011);
      @(negedge ref_clk);
      chk(result_value, 16'h000e);
      // reset in the middle of a divide
      op_code = bwau_pkg::BWAU_DIV;
      @(negedge ref_clk);
      op_valid = 1'b0;
      rst = 1'b1;
      @(negedge ref_clk);
      chk(16'(busy), 16'h0000);
      chk(16'(condition_flags_register), 16'h0000);
      rst = 1'b0;
      run(rows[0]);
      report_and_stop();
   end
endmodule
